// ### core_status_pkg.sv
// Constants shared by the core status, counter control and return stack logic.
// Assumes a single 50 MHz core clock and a 32-bit Avalon-MM register port.
`default_nettype none

package core_status_pkg;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [4:0] counter_control_idx    = 5'h05;
  localparam logic [4:0] cpu_status_control_idx = 5'h06;
  localparam logic [6:0] counter_control_addr    = 7'h14;
  localparam logic [6:0] cpu_status_control_addr = 7'h18;

  // Status register field positions.
  localparam int stack_space_bit   = 5;
  localparam int global_mask_bit   = 4;
  localparam int wdt_expiry_bit    = 3;
  localparam int sleep_entered_bit = 2;
  localparam int power_on_bit      = 1;
  localparam int brownout_bit      = 0;

  // Counter control field positions.
  localparam int ext_edge_bit    = 7;
  localparam int count_edge_bit  = 6;
  localparam int count_src_bit   = 5;
  localparam int prescale_hi_bit = 4;
  localparam int prescale_lo_bit = 1;

  // Reset values and write masks.
  localparam logic [7:0] counter_control_rst = 8'h00;
  localparam logic       global_mask_rst     = 1'b1;
  localparam logic [7:0] cpu_status_wmask    = 8'h13;
  localparam logic [7:0] counter_control_wmask = 8'hfe;

  // Return stack geometry.
  localparam int stack_depth = 16;
  localparam int stack_width = 16;
  localparam logic [3:0] stack_top_ptr = 4'hf;
  localparam logic [3:0] stack_rst_ptr = 4'h0;

  // Largest prescale exponent, giving 1:256.
  localparam logic [3:0] prescale_max_exp = 4'h8;

endpackage : core_status_pkg

`default_nettype wire

// ### pin_edge_detect.sv
// Two-stage synchroniser with a selectable edge detector for one pin.
// Assumes the pin is asynchronous to mclk; emits a one-cycle pulse.
`default_nettype none

module pin_edge_detect (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rstn,
  // Pin and edge choice: one picks rising, zero picks falling.
  input  wire logic pin_async,
  input  wire logic rising_sel,
  // Detected edge.
  output logic      edge_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pulse_reg;
  logic rise_w;
  logic fall_w;

  // Only the second stage and later are looked at, to keep metastability out.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      pulse_reg <= rising_sel ? rise_w : fall_w;
    end
  end

  assign rise_w     = sync2_reg & ~prev_reg;
  assign fall_w     = ~sync2_reg & prev_reg;
  assign edge_pulse = pulse_reg;

endmodule : pin_edge_detect

`default_nettype wire

// ### return_stack.sv
// Sixteen-entry circular return-address stack with its space flag.
// Assumes push and pop are one-cycle pulses from the instruction sequencer.
`default_nettype none

module return_stack
  import core_status_pkg::*;
(
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // Stack operations.
  input  wire logic                   push,
  input  wire logic [stack_width-1:0] push_data,
  input  wire logic                   pop,
  output logic      [stack_width-1:0] pop_data,
  // Space flag, one while the stack has room.
  output logic                        space_flag
);

  logic [stack_width-1:0] mem [stack_depth];
  logic [3:0]             ptr_reg;
  logic [3:0]             ptr_up;
  logic [3:0]             ptr_down;
  logic                   locked_reg;
  logic [stack_width-1:0] pop_data_reg;
  logic                   do_push;
  logic                   do_pop;

  // A pop takes priority when both arrive together.
  assign do_pop   = pop;
  assign do_push  = push & ~pop;
  assign ptr_up   = ptr_reg + 4'h1;
  assign ptr_down = ptr_reg - 4'h1;

  // Pointer and lock; a push at the top position wraps and locks the flag.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg    <= stack_rst_ptr;
      locked_reg <= 1'b0;
    end else if (do_push) begin
      ptr_reg <= ptr_up;
      if (ptr_reg == stack_top_ptr) begin
        locked_reg <= 1'b1;
      end
    end else if (do_pop) begin
      ptr_reg <= ptr_down;
    end
  end

  // Entries hold no reset; old ones are overwritten in turn once full.
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[ptr_up] <= push_data;
    end
  end

  // Popped address is held until the next pop.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pop_data_reg <= '0;
    end else if (do_pop) begin
      pop_data_reg <= mem[ptr_reg];
    end
  end

  // An underflow lands the pointer at the top, which clears the flag.
  assign space_flag = (ptr_reg != stack_top_ptr) & ~locked_reg;
  assign pop_data   = pop_data_reg;

endmodule : return_stack

`default_nettype wire

// ### core_status_and_call_stack.sv
// Core status and control register, counter control register and return stack.
// Assumes the sequencer and reset logic share mclk; pins arrive asynchronously.
`default_nettype none

// Notes on behaviour
// - Software cannot write expiry, sleep or space flags.
// - Status bits seven and six read zero.
// - Space flag reads one while stack has room.
// - Global mask set blocks every interrupt source.
// - Expiry flag set by power-up, clear, sleep; timeout clears.
// - Sleep flag set by power-up and clear; sleep clears.
// - Power-on flag cleared by power-on reset or a software write of zero.
// - Brown-out flag cleared on brown-out when enabled.
// - External interrupt edge select: one rising, zero falling.
// - Count edge select applies only to external source.
// - Source select: one internal cycle, zero pin.
// - Prescale divides by two to code; 1xxx is 256.
// - Sixteen by sixteen stack, pointer hidden from software.
// - Push on subroutine jumps and interrupt acknowledge.
// - Pop on returns; high latch left untouched.
// - Every reset zeroes pointer and sets space flag.
// - Pointer at top clears flag; wrap locks it.
// - Pop first, then push, locks flag clear.
// - Stack is circular; extra pushes overwrite oldest.
// - No underflow flag beyond the space flag.
module core_status_and_call_stack
  import core_status_pkg::*;
(
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // Avalon-MM register port.
  input  wire logic [6:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Reset causes, held by the reset logic until after rstn releases.
  input  wire logic                   por_cause,
  input  wire logic                   bor_cause,
  input  wire logic                   wdt_cause,
  input  wire logic                   brownout_enable_cfg,
  // Sequencer events, one-cycle pulses.
  input  wire logic                   watchdog_clear_instr,
  input  wire logic                   sleep_instr,
  input  wire logic                   watchdog_timeout,
  input  wire logic                   push_req,
  input  wire logic [stack_width-1:0] push_pc,
  input  wire logic                   pop_req,
  output logic      [stack_width-1:0] pop_pc,
  // Interrupt gating.
  input  wire logic                   irq_request,
  output logic                        irq_to_core,
  output logic                        global_irq_mask,
  // Pins and counter enables.
  input  wire logic                   ext_irq_pin,
  input  wire logic                   count_clock_pin,
  input  wire logic                   instr_cycle_en,
  output logic                        ext_irq_edge,
  output logic                        count_edge_flag,
  output logic                        count_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Bus path signals.
  logic       ack_reg;
  logic       req_w;
  logic       wr_fire;
  logic       rd_take;
  logic       hit_cc;
  logic       hit_cs;
  logic       lane0_wr;
  logic [7:0] wbyte;
  logic [31:0] readdata_reg;
  logic [31:0] rd_mux;

  // One wait cycle per access keeps the read path fully registered.
  assign req_w           = avs_read | avs_write;
  assign avs_waitrequest = req_w & ~ack_reg;
  assign wr_fire         = avs_write & ack_reg;
  assign rd_take         = avs_read & ~ack_reg;

  // Address and lane decode.
  assign hit_cc          = (avs_address == counter_control_addr);
  assign hit_cs          = (avs_address == cpu_status_control_addr);
  assign lane0_wr        = wr_fire & avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];

  // Handshake state; the ack lasts one cycle,
  // so every request completes exactly once.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_w & ~ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause capture.

  // Release marker.
  logic started_reg;
  logic capture_w;

  // The cause levels are caught on every edge under reset and again on the first edge after release.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // High under reset and for one cycle after release.
  assign capture_w = ~started_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status register.

  // Status fields, one flop each except the space flag, which comes from the stack.
  logic global_mask_reg;
  logic wdt_expiry_reg;
  logic sleep_entered_reg;
  logic power_on_reg;
  logic brownout_reg;
  logic stack_space_flag;
  logic cs_wr;
  logic [7:0] cs_view;

  // Lane zero carries the data.
  assign cs_wr = lane0_wr & hit_cs;

  // The mask is plain control state and returns to its disabled value on reset.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      global_mask_reg <= global_mask_rst;
    end else if (cs_wr) begin
      global_mask_reg <= wbyte[global_mask_bit];
    end
  end

  // Expiry and sleep flags must survive a watchdog reset, so they carry no
  // asynchronous reset; the captured cause decides their value instead.
  always_ff @(posedge mclk) begin
    if (capture_w && por_cause) begin
      wdt_expiry_reg    <= 1'b1;
      sleep_entered_reg <= 1'b1;
    end else if (capture_w && wdt_cause) begin
      wdt_expiry_reg    <= 1'b0;
    end else begin
      // Software writes never reach these flags.
      // Clear beats sleep, sleep beats timeout.
      if (watchdog_clear_instr) begin
        wdt_expiry_reg    <= 1'b1;
        sleep_entered_reg <= 1'b1;
      end else if (sleep_instr) begin
        wdt_expiry_reg    <= 1'b1;
        sleep_entered_reg <= 1'b0;
      end else if (watchdog_timeout) begin
        wdt_expiry_reg    <= 1'b0;
      end
    end
  end

  // Reset-cause flags keep their value across other resets.
  always_ff @(posedge mclk) begin
    if (capture_w && por_cause) begin
      power_on_reg <= 1'b0;
    end else if (cs_wr) begin
      power_on_reg <= wbyte[power_on_bit];
    end
    // Only while detection is enabled.
    if (capture_w && bor_cause && brownout_enable_cfg) begin
      brownout_reg <= 1'b0;
    end else if (cs_wr) begin
      brownout_reg <= wbyte[brownout_bit];
    end
  end

  // Assembled view; top two bits are not implemented.
  always_comb begin
    cs_view                    = 8'h00;
    cs_view[stack_space_bit]   = stack_space_flag;
    cs_view[global_mask_bit]   = global_mask_reg;
    cs_view[wdt_expiry_bit]    = wdt_expiry_reg;
    cs_view[sleep_entered_bit] = sleep_entered_reg;
    cs_view[power_on_bit]      = power_on_reg;
    cs_view[brownout_bit]      = brownout_reg;
  end

  // The mask overrides every individually enabled source.
  assign global_irq_mask = global_mask_reg;
  assign irq_to_core     = irq_request & ~global_mask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter control register.

  // Stored byte and its fields.
  logic [7:0] cc_reg;
  logic       cc_wr;
  logic       ext_edge_sel;
  logic       count_edge_sel;
  logic       count_source_sel;
  logic [3:0] prescale_sel;

  // Other lanes are ignored.
  assign cc_wr = lane0_wr & hit_cc;

  // Bit zero is unimplemented and stays zero.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cc_reg <= counter_control_rst;
    end else if (cc_wr) begin
      cc_reg <= wbyte & counter_control_wmask;
    end
  end

  // Decoded control fields.
  assign ext_edge_sel     = cc_reg[ext_edge_bit];
  assign count_edge_sel   = cc_reg[count_edge_bit];
  assign count_source_sel = cc_reg[count_src_bit];
  assign prescale_sel     = cc_reg[prescale_hi_bit:prescale_lo_bit];

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges.

  // Pulse before the source gate.
  logic count_pin_edge;

  // External interrupt pin, edge chosen by software.
  pin_edge_detect ext_irq_det (
    .mclk       (mclk),
    .rstn       (rstn),
    .pin_async  (ext_irq_pin),
    .rising_sel (ext_edge_sel),
    .edge_pulse (ext_irq_edge)
  );

  // Count clock pin, edge chosen by software.
  pin_edge_detect count_pin_det (
    .mclk       (mclk),
    .rstn       (rstn),
    .pin_async  (count_clock_pin),
    .rising_sel (count_edge_sel),
    .edge_pulse (count_pin_edge)
  );

  // With the internal source the pin edge is ignored altogether.
  assign count_edge_flag = count_pin_edge & ~count_source_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler.

  // Divider state.
  logic       src_event;
  logic [3:0] exp_w;
  logic [7:0] limit_w;
  logic [7:0] pre_cnt_reg;
  logic       tick_reg;

  // Source and terminal count.
  assign src_event = count_source_sel ? instr_cycle_en : count_edge_flag;
  assign exp_w     = prescale_sel[3] ? prescale_max_exp : prescale_sel;
  assign limit_w   = 8'((9'h001 << exp_w) - 9'h001);

  // Restarting on a control write avoids a stale count under a new ratio.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else if (cc_wr) begin
      pre_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else if (src_event) begin
      if (pre_cnt_reg >= limit_w) begin
        pre_cnt_reg <= 8'h00;
        tick_reg    <= 1'b1;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 8'h01;
        tick_reg    <= 1'b0;
      end
    end else begin
      tick_reg <= 1'b0;
    end
  end

  // Feeds the counter datapath.
  assign count_tick = tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Return stack; its pointer has no bus path.

  // Requests go straight through.
  return_stack stack_u (
    .mclk       (mclk),
    .rstn       (rstn),
    .push       (push_req),
    .push_data  (push_pc),
    .pop        (pop_req),
    .pop_data   (pop_pc),
    .space_flag (stack_space_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Unmapped addresses read zero and ignore writes.
  always_comb begin
    if (hit_cs) begin
      rd_mux = {24'h000000, cs_view};
    end else if (hit_cc) begin
      rd_mux = {24'h000000, cc_reg};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Captured in the wait cycle so it stands at the completing edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata_reg <= 32'h00000000;
    end else if (rd_take) begin
      readdata_reg <= rd_mux;
    end
  end

  // Output from a flip-flop.
  assign avs_readdata = readdata_reg;

endmodule : core_status_and_call_stack

`default_nettype wire

// ### core_status_asserts.sv
// Concurrent checks on the core status block, watching its ports only.
// Assumes one mclk domain and the asynchronous active-low rstn.
`default_nettype none

module core_status_asserts
  import core_status_pkg::*;
(
  // Clock and reset.
  input wire logic                   mclk,
  input wire logic                   rstn,
  // Register port.
  input wire logic [6:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // Stack and interrupt side.
  input wire logic                   push_req,
  input wire logic [stack_width-1:0] push_pc,
  input wire logic                   pop_req,
  input wire logic [stack_width-1:0] pop_pc,
  input wire logic                   irq_request,
  input wire logic                   irq_to_core,
  input wire logic                   global_irq_mask,
  // Pins and their pulses.
  input wire logic                   ext_irq_pin,
  input wire logic                   count_clock_pin,
  input wire logic                   ext_irq_edge,
  input wire logic                   count_edge_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // A status read completes in this cycle.
  wire status_rd_done = avs_read && !avs_waitrequest
                        && avs_address == cpu_status_control_addr;

  // A push directly followed by a pop must return the pushed value.
  sequence push_then_pop;
    push_req && !pop_req ##1 pop_req && !push_req;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_MASK_GATE: assert property (irq_to_core == (irq_request && !global_irq_mask))
    else $error("interrupt gate disagrees with the mask");
  AST_MASK_READ: assert property (status_rd_done |-> avs_readdata[4] == global_irq_mask)
    else $error("mask bit read back differs from mask output");
  AST_STATUS_TOP: assert property (status_rd_done |-> avs_readdata[31:6] == 26'h0)
    else $error("unimplemented status bits read nonzero");
  AST_POP_PAIR: assert property (push_then_pop |=> pop_pc == $past(push_pc, 2))
    else $error("pop did not return the newest push");
  AST_POP_STABLE: assert property (!pop_req |=> $stable(pop_pc))
    else $error("pop data moved without a pop");
  AST_EXT_PULSE: assert property (ext_irq_edge |=> !ext_irq_edge)
    else $error("interrupt edge pulse longer than one cycle");
  // The pin change lies between two and five samples back.
  AST_EXT_CAUSE: assert property (ext_irq_edge |-> $past(ext_irq_pin, 2) != $past(ext_irq_pin, 5))
    else $error("interrupt edge pulse without a pin change");
  AST_CNT_PULSE: assert property (count_edge_flag |=> !count_edge_flag)
    else $error("count edge pulse longer than one cycle");
  AST_CNT_CAUSE: assert property (count_edge_flag |-> $past(count_clock_pin, 2) != $past(count_clock_pin, 5))
    else $error("count edge pulse without a pin change");

endmodule : core_status_asserts

bind core_status_and_call_stack core_status_asserts u_asserts (
  .mclk, .rstn, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .push_req, .push_pc, .pop_req, .pop_pc, .irq_request, .irq_to_core,
  .global_irq_mask, .ext_irq_pin, .count_clock_pin, .ext_irq_edge, .count_edge_flag
);

`default_nettype wire

// ### seq_model.sv
// Instruction sequencer stand-in: issues stack and watchdog events.
// Assumes the core block samples its event inputs on the rising mclk edge.
`default_nettype none

module seq_model
  import core_status_pkg::*;
(
  // Clock.
  input  wire logic                   mclk,
  // Event pulses towards the core block.
  output logic                        push_req,
  output logic      [stack_width-1:0] push_pc,
  output logic                        pop_req,
  output logic                        watchdog_clear_instr,
  output logic                        sleep_instr,
  output logic                        watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet at time zero.
  initial begin
    push_req             = 1'b0;
    push_pc              = '0;
    pop_req              = 1'b0;
    watchdog_clear_instr = 1'b0;
    sleep_instr          = 1'b0;
    watchdog_timeout     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One event per call; calls back to back give back-to-back events, and an
  // idle call between them paces the sequencer slowly. Kind 0 push (call or
  // interrupt acknowledge), 1 pop (returns), 2 clear, 3 sleep, 4 timeout.
  // An idle push_pc is inverted so stale data never looks valid.
  task automatic op(input int kind, input logic [stack_width-1:0] pc);
    @(posedge mclk);
    push_req             <= (kind == 0);
    push_pc              <= (kind == 0) ? pc : ~push_pc;
    pop_req              <= (kind == 1);
    watchdog_clear_instr <= (kind == 2);
    sleep_instr          <= (kind == 3);
    watchdog_timeout     <= (kind == 4);
  endtask : op

  task automatic idle();
    op(-1, '0);
  endtask : idle

endmodule : seq_model

`default_nettype wire

// ### tb_core_status_and_call_stack.sv
// Self-checking bench for the core status, counter control and return stack.
// Assumes seq_model stands in for the sequencer and the bench is bus master.
`default_nettype none

module tb_core_status_and_call_stack
  import core_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] sa = cpu_status_control_addr;
  localparam logic [6:0] ca = counter_control_addr;
  logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        por_cause, bor_cause, wdt_cause, brownout_enable_cfg;
  logic        watchdog_clear_instr, sleep_instr, watchdog_timeout;
  logic        push_req, pop_req, irq_request, irq_to_core, global_irq_mask;
  logic [15:0] push_pc, pop_pc;
  logic        ext_irq_pin, count_clock_pin, instr_cycle_en;
  logic        ext_irq_edge, count_edge_flag, count_tick;
  logic [7:0]  q;
  logic [7:0]  ev_exp [3] = '{8'h37, 8'h3b, 8'h3f};
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          ext_n, cef_n, tick_n;

  core_status_and_call_stack DUT (
    .mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .por_cause, .bor_cause,
    .wdt_cause, .brownout_enable_cfg, .watchdog_clear_instr, .sleep_instr,
    .watchdog_timeout, .push_req, .push_pc, .pop_req, .pop_pc, .irq_request,
    .irq_to_core, .global_irq_mask, .ext_irq_pin, .count_clock_pin,
    .instr_cycle_en, .ext_irq_edge, .count_edge_flag, .count_tick
  );
  seq_model m (
    .mclk, .push_req, .push_pc, .pop_req, .watchdog_clear_instr, .sleep_instr,
    .watchdog_timeout
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang limit and pulse counters; counting on the falling edge
  // keeps clear of the updates made at the rising edge.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      stop_test();
    end
  end
  always @(negedge mclk) begin
    ext_n  += int'(ext_irq_edge === 1'b1);
    cef_n  += int'(count_edge_flag === 1'b1);
    tick_n += int'(count_tick === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Cause levels stay put through the capture edge after release.
  task automatic do_reset(input logic p, input logic b, input logic w);
    @(posedge mclk);
    rstn      <= 1'b0;
    por_cause <= p;
    bor_cause <= b;
    wdt_cause <= w;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    por_cause <= 1'b0;
    bor_cause <= 1'b0;
    wdt_cause <= 1'b0;
  endtask : do_reset

  // Avalon-MM cycle: held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge mclk);
    avs_address    <= a;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] mk);
    bus(1'b0, a, 8'h00, 4'hf);
    check(16'(q & mk), 16'(e));
  endtask : rd_chk

  function automatic logic [15:0] pv(input int i);
    return 16'ha000 + 16'(i);
  endfunction : pv

  // Back-to-back pops; each result is looked at one cycle after its pop.
  task automatic pop_run(input int n, input int t);
    for (int i = 0; i < n; i++) begin
      m.op(1, '0);
      if (i > 0) begin
        @(negedge mclk);
        check(pop_pc, pv(t - i + 1));
      end
    end
    m.idle();
    @(negedge mclk);
    check(pop_pc, pv(t - n + 1));
  endtask : pop_run

  // Three pin pulses, both pins together, 8 cycles per level.
  task automatic pins(input int e);
    ext_n  = 0;
    cef_n  = 0;
    tick_n = 0;
    for (int j = 0; j < 3; j++) begin
      ext_irq_pin     <= 1'b1;
      count_clock_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      if (j == 0 && e < 2)
        check(16'(ext_n + cef_n), 16'(2 * e));
      ext_irq_pin     <= 1'b0;
      count_clock_pin <= 1'b0;
      repeat (8) @(posedge mclk);
    end
    check(16'(ext_n), 16'h3);
  endtask : pins

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {bor_cause, wdt_cause, brownout_enable_cfg, irq_request} = '0;
    {ext_irq_pin, count_clock_pin, instr_cycle_en} = '0;
    por_cause = 1'b1;
    do_reset(1'b1, 1'b0, 1'b0);
    rd_chk(sa, 8'h3c, 8'hfe);
    rd_chk(ca, 8'h00, 8'hff);
    bus(1'b1, sa, 8'hff, 4'h1);
    rd_chk(sa, 8'h3f, 8'hff);
    bus(1'b1, sa, 8'h00, 4'h1);
    rd_chk(sa, 8'h2c, 8'hff);
    irq_request <= 1'b1;
    @(negedge mclk);
    check(16'(irq_to_core), 16'h1);
    bus(1'b1, sa, 8'h13, 4'h1);
    @(negedge mclk);
    check(16'(irq_to_core), 16'h0);
    bus(1'b1, sa, 8'h00, 4'h0);
    rd_chk(sa, 8'h3f, 8'hff);
    bus(1'b1, 7'h00, 8'hff, 4'h1);
    rd_chk(7'h00, 8'h00, 8'hff);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      m.op(4 - i, '0);
      m.idle();
      rd_chk(sa, ev_exp[i], 8'hff);
    end
    $display("test events done");
    for (int i = 1; i <= 15; i++) m.op(0, pv(i));
    m.idle();
    rd_chk(sa, 8'h1f, 8'hff);
    pop_run(15, 15);
    rd_chk(sa, 8'h3f, 8'hff);
    for (int i = 1; i <= 18; i++) m.op(0, pv(i));
    pop_run(4, 18);
    rd_chk(sa, 8'h1f, 8'hff);
    $display("test stack done");
    do_reset(1'b0, 1'b0, 1'b1);
    rd_chk(sa, 8'h37, 8'hff);
    m.op(1, '0);
    m.idle();
    rd_chk(sa, 8'h17, 8'hff);
    m.op(0, 16'h1234);
    m.idle();
    rd_chk(sa, 8'h17, 8'hff);
    brownout_enable_cfg <= 1'b1;
    do_reset(1'b0, 1'b1, 1'b0);
    rd_chk(sa, 8'h36, 8'hff);
    $display("test resets done");
    bus(1'b1, ca, 8'hff, 4'h1);
    rd_chk(ca, 8'hfe, 8'hff);
    bus(1'b1, ca, 8'h00, 4'he);
    rd_chk(ca, 8'hfe, 8'hff);
    for (int k = 0; k < 10; k++) begin
      bus(1'b1, ca, {3'b001, 4'((k < 9) ? k : 15), 1'b0}, 4'h1);
      tick_n = 0;
      instr_cycle_en <= 1'b1;
      repeat (256) @(posedge mclk);
      instr_cycle_en <= 1'b0;
      repeat (4) @(posedge mclk);
      check(16'(tick_n), 16'(256 >> ((k < 8) ? k : 8)));
    end
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, ca, {e[0], e[0], 6'h00}, 4'h1);
      pins(e);
      check(16'(cef_n), 16'h3);
      check(16'(tick_n), 16'h3);
    end
    bus(1'b1, ca, 8'he0, 4'h1);
    pins(2);
    check(16'(cef_n), 16'h0);
    check(16'(tick_n), 16'h0);
    $display("test counter done");
    stop_test();
  end

endmodule : tb_core_status_and_call_stack

`default_nettype wire
